// [rtl/timer8_pkg.sv]
package timer8_pkg;

  // Counter width and extremes
  localparam int         CNT_W      = 8;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL    = 8'hff;

  // Values after reset
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] CMP_RST    = 8'h00;
  localparam logic [2:0] FLAG_RST   = 3'h0;
  localparam logic [2:0] MASK_RST   = 3'h0;

  // Flag and mask bit positions
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMA = 1;
  localparam int FLAG_CMB = 2;

  // Tick source select codes
  localparam logic [2:0] TICK_STOP = 3'h0;
  localparam logic [2:0] TICK_DIV1 = 3'h1;

  // Waveform mode codes
  localparam logic [2:0] WGM_NORMAL   = 3'h0;
  localparam logic [2:0] WGM_PC_MAX   = 3'h1;
  localparam logic [2:0] WGM_CTC      = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_OCA   = 3'h5;
  localparam logic [2:0] WGM_FAST_OCA = 3'h7;

  // Compare output mode codes
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // Processor write strobes with data
  typedef struct packed {
    logic       count_we;
    logic       cmp_a_we;
    logic       cmp_b_we;
    logic [7:0] wdata;
  } cpu_write_t;

  // Flag clear requests: software write-one or interrupt service
  typedef struct packed {
    logic [2:0] clear;
  } flag_clear_t;

endpackage : timer8_pkg

// [rtl/timer8_core.sv]
`timescale 1ns/1ps
module timer8_core
  import timer8_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Power gating and clocking control
  input  wire logic        timer_power_reduction_bit,
  input  wire logic        async_clock_select,
  input  wire logic [2:0]  tick_source_select,
  input  wire logic        prescale_tick,
  input  wire logic        crystal_osc_in,
  // Mode control
  input  wire logic [2:0]  waveform_mode_field,
  input  wire logic [1:0]  compare_output_mode_a,
  input  wire logic [1:0]  compare_output_mode_b,
  input  wire logic        force_compare_strobe_a,
  input  wire logic        force_compare_strobe_b,
  // Register writes and flag handling
  input  wire cpu_write_t  cpu_wr,
  input  wire flag_clear_t flag_clr,
  input  wire logic [2:0]  timer_mask_register,
  // Register read-back
  output logic [7:0]       counter_value,
  output logic [7:0]       compare_value_a,
  output logic [7:0]       compare_value_b,
  output logic [2:0]       timer_flag_register,
  // Waveform and interrupt outputs
  output logic             compare_output_a,
  output logic             compare_output_b,
  output logic [2:0]       irq_reg,
  output logic             bottom_reg,
  output logic             crystal_osc_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Fast and phase-correct modes both buffer the compare values
  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = (m == WGM_PC_MAX) || (m == WGM_FAST_MAX) ||
             (m == WGM_PC_OCA) || (m == WGM_FAST_OCA);
  endfunction : is_pwm

  function automatic logic is_fast(input logic [2:0] m);
    is_fast = (m == WGM_FAST_MAX) || (m == WGM_FAST_OCA);
  endfunction : is_fast

  // Output action at a match: toggle/clear/set, mode zero holds
  function automatic logic wave_next(input logic [1:0] com,
                                     input logic       cur,
                                     input logic       pwm,
                                     input logic       up);
    if (com == COM_OFF)
    begin
      wave_next = cur;
    end
    else if (!pwm)
    begin
      wave_next = (com == COM_TOGGLE) ? ~cur : (com == COM_SET);
    end
    else
    begin
      // Non-inverting clears on match when counting up
      wave_next = (com == COM_CLEAR) ? ~up : up;
    end
  endfunction : wave_next

  ////////////////////////////////////////////////////////////////////////////
  // Crystal input synchroniser and tick generation

  logic       xtal_meta_reg;
  logic       xtal_sync_reg;
  logic       xtal_prev_reg;
  logic       tick;
  logic       enabled;

  // Two flops before anything looks at the pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      xtal_meta_reg <= 1'b0;
      xtal_sync_reg <= 1'b0;
      xtal_prev_reg <= 1'b0;
    end
    else
    begin
      xtal_meta_reg <= crystal_osc_in;
      xtal_sync_reg <= xtal_meta_reg;
      xtal_prev_reg <= xtal_sync_reg;
    end
  end

  // Power-reduction bit high stops the ticks and the oscillator drive; writes, clears and forcing still act
  assign enabled = !timer_power_reduction_bit;

  // Crystal rising edge replaces the io clock when selected
  always_comb
  begin
    if (!enabled || tick_source_select == TICK_STOP)
    begin
      tick = 1'b0;
    end
    else if (async_clock_select)
    begin
      tick = xtal_sync_reg && !xtal_prev_reg;
    end
    else if (tick_source_select == TICK_DIV1)
    begin
      tick = 1'b1;
    end
    else
    begin
      tick = prescale_tick;
    end
  end

  // Oscillator drive is an inverted echo of the input, driven low when gated or not selected
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      crystal_osc_out <= 1'b0;
    end
    else
    begin
      crystal_osc_out <= enabled && async_clock_select && !xtal_sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter unit

  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic       down_reg;
  logic       down_next;
  logic [7:0] cmp_a_reg;
  logic [7:0] cmp_b_reg;
  logic [7:0] buf_a_reg;
  logic [7:0] buf_b_reg;
  logic [7:0] top_val;
  logic       at_top;
  logic       at_max;
  logic       at_bottom;
  logic       pwm;
  logic       fast;

  assign pwm       = is_pwm(waveform_mode_field);
  assign fast      = is_fast(waveform_mode_field);
  // Top is compare A in the upper modes, else the fixed maximum
  assign top_val   = waveform_mode_field[2] ? cmp_a_reg : MAX_VAL;
  assign at_top    = (count_reg == top_val);
  assign at_max    = (count_reg == MAX_VAL);
  assign at_bottom = (count_reg == BOTTOM_VAL);

  // Sequence per mode; wrap at max in normal mode
  always_comb
  begin
    count_next = count_reg;
    down_next  = down_reg;
    if (waveform_mode_field == WGM_CTC)
    begin
      count_next = (count_reg == cmp_a_reg) ? BOTTOM_VAL : count_reg + 8'h01;
      down_next  = 1'b0;
    end
    else if (fast)
    begin
      count_next = at_top ? BOTTOM_VAL : count_reg + 8'h01;
      down_next  = 1'b0;
    end
    else if (pwm)
    begin
      // Dual slope: turn at top and at bottom
      if (down_reg)
      begin
        count_next = at_bottom ? count_reg + 8'h01 : count_reg - 8'h01;
        down_next  = !at_bottom;
      end
      else
      begin
        count_next = at_top ? count_reg - 8'h01 : count_reg + 8'h01;
        down_next  = at_top;
      end
    end
    else
    begin
      count_next = count_reg + 8'h01;
      down_next  = 1'b0;
    end
  end

  // Processor write has priority over any tick operation
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_reg <= COUNT_RST;
      down_reg  <= 1'b0;
    end
    else if (cpu_wr.count_we)
    begin
      count_reg <= cpu_wr.wdata;
    end
    else if (tick)
    begin
      count_reg <= count_next;
      down_reg  <= down_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare registers with optional double buffer

  logic update_pt;

  // Fast PWM loads at top; dual slope loads at top while counting up
  assign update_pt = tick && (fast ? at_top : (at_top && !down_reg));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmp_a_reg <= CMP_RST;
      cmp_b_reg <= CMP_RST;
      buf_a_reg <= CMP_RST;
      buf_b_reg <= CMP_RST;
    end
    else
    begin
      if (cpu_wr.cmp_a_we)
      begin
        buf_a_reg <= cpu_wr.wdata;
      end
      if (cpu_wr.cmp_b_we)
      begin
        buf_b_reg <= cpu_wr.wdata;
      end
      // Buffer bypassed outside PWM so writes land at once
      if (!pwm && cpu_wr.cmp_a_we)
      begin
        cmp_a_reg <= cpu_wr.wdata;
      end
      else if (pwm && update_pt)
      begin
        cmp_a_reg <= buf_a_reg;
      end
      if (!pwm && cpu_wr.cmp_b_we)
      begin
        cmp_b_reg <= cpu_wr.wdata;
      end
      else if (pwm && update_pt)
      begin
        cmp_b_reg <= buf_b_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Match detection, blocking and flags

  logic       block_reg;
  logic [1:0] match;
  logic [1:0] match_pend_reg;
  logic [2:0] flag_reg;
  logic [2:0] flag_set;
  logic       ovf_evt;

  // Counter write arms a block that the next tick consumes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      block_reg <= 1'b0;
    end
    else if (cpu_wr.count_we)
    begin
      block_reg <= 1'b1;
    end
    else if (tick)
    begin
      block_reg <= 1'b0;
    end
  end

  assign match[0] = (count_reg == cmp_a_reg) && !block_reg && !cpu_wr.count_we;
  assign match[1] = (count_reg == cmp_b_reg) && !block_reg && !cpu_wr.count_we;

  // Match seen on this tick is flagged on the following tick
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      match_pend_reg <= 2'h0;
    end
    else if (tick)
    begin
      match_pend_reg <= match;
    end
  end

  // Overflow at max wrap, at top in fast PWM, at bottom in dual slope
  assign ovf_evt = tick && !cpu_wr.count_we &&
                   (fast ? at_top : (pwm ? (at_bottom && down_reg) : at_max));

  assign flag_set[FLAG_OVF] = ovf_evt;
  assign flag_set[FLAG_CMA] = tick && match_pend_reg[0];
  assign flag_set[FLAG_CMB] = tick && match_pend_reg[1];

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flag_reg <= FLAG_RST;
    end
    else
    begin
      flag_reg <= (flag_reg & ~flag_clr.clear) | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform generator

  logic oc_a_reg;
  logic oc_b_reg;

  // Output state is untouched by mode writes; output mode used live
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      oc_a_reg <= 1'b0;
    end
    else if (!pwm && force_compare_strobe_a)
    begin
      oc_a_reg <= wave_next(compare_output_mode_a, oc_a_reg, 1'b0, 1'b1);
    end
    else if (tick && match[0])
    begin
      oc_a_reg <= wave_next(compare_output_mode_a, oc_a_reg, pwm, !down_reg);
    end
    else if (tick && fast && at_bottom && compare_output_mode_a[1])
    begin
      oc_a_reg <= !compare_output_mode_a[0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      oc_b_reg <= 1'b0;
    end
    else if (!pwm && force_compare_strobe_b)
    begin
      oc_b_reg <= wave_next(compare_output_mode_b, oc_b_reg, 1'b0, 1'b1);
    end
    else if (tick && match[1])
    begin
      oc_b_reg <= wave_next(compare_output_mode_b, oc_b_reg, pwm, !down_reg);
    end
    else if (tick && fast && at_bottom && compare_output_mode_b[1])
    begin
      oc_b_reg <= !compare_output_mode_b[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  // Mirrors are one cycle behind the state; irq gated by mask
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      counter_value       <= COUNT_RST;
      compare_value_a     <= CMP_RST;
      compare_value_b     <= CMP_RST;
      timer_flag_register <= FLAG_RST;
      compare_output_a    <= 1'b0;
      compare_output_b    <= 1'b0;
      irq_reg             <= 3'h0;
      bottom_reg          <= 1'b0;
    end
    else
    begin
      counter_value       <= count_reg;
      compare_value_a     <= pwm ? buf_a_reg : cmp_a_reg;
      compare_value_b     <= pwm ? buf_b_reg : cmp_b_reg;
      timer_flag_register <= flag_reg;
      compare_output_a    <= oc_a_reg;
      compare_output_b    <= oc_b_reg;
      irq_reg             <= flag_reg & timer_mask_register;
      bottom_reg          <= at_bottom;
    end
  end

endmodule : timer8_core

// [testbench/timer8_core_checker.sv]
`timescale 1ns/1ps
module timer8_core_checker
  import timer8_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Control
  input wire logic        timer_power_reduction_bit,
  input wire logic        async_clock_select,
  input wire logic [2:0]  tick_source_select,
  input wire logic [2:0]  waveform_mode_field,
  input wire logic [1:0]  compare_output_mode_a,
  input wire logic        force_compare_strobe_a,
  input wire cpu_write_t  cpu_wr,
  input wire flag_clear_t flag_clr,
  input wire logic [2:0]  timer_mask_register,
  // Observed outputs
  input wire logic [7:0]  counter_value,
  input wire logic [2:0]  timer_flag_register,
  input wire logic        compare_output_a,
  input wire logic [2:0]  irq_reg,
  input wire logic        bottom_reg,
  input wire logic        crystal_osc_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // No tick source and no write: counter must sit still
  sequence idle_cyc;
    (tick_source_select == TICK_STOP || timer_power_reduction_bit) && !cpu_wr.count_we;
  endsequence
  // Plain ticking every clock in normal mode
  sequence run_cyc;
    tick_source_select == TICK_DIV1 && !async_clock_select && !timer_power_reduction_bit
      && waveform_mode_field == WGM_NORMAL && !cpu_wr.count_we;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  irq_mask_gate_a: assert property (
    irq_reg == (timer_flag_register & $past(timer_mask_register)))
    else $error("interrupt request not flag and mask");
  // Skip two edges after reset since outputs are forced low there
  bottom_match_a: assert property (
    !$past(rst) && !$past(rst, 2) |-> bottom_reg == (counter_value == BOTTOM_VAL))
    else $error("bottom indication wrong");
  write_load_a: assert property (
    cpu_wr.count_we |-> ##2 counter_value == $past(cpu_wr.wdata, 2))
    else $error("counter write not loaded");
  stop_hold_a: assert property (
    idle_cyc [*3] |-> $stable(counter_value))
    else $error("counter moved while stopped");
  count_step_a: assert property (
    run_cyc [*3] |-> counter_value == 8'($past(counter_value) + 8'h01))
    else $error("counter did not step by one");
  flag_clear_a: assert property (
    flag_clr.clear[FLAG_CMB] && tick_source_select == TICK_STOP
      |-> ##2 !timer_flag_register[FLAG_CMB])
    else $error("compare flag not cleared");
  // Output pin is one register behind the state, so look two edges on
  force_toggle_a: assert property (
    force_compare_strobe_a && waveform_mode_field == WGM_NORMAL
      && compare_output_mode_a == COM_TOGGLE && tick_source_select == TICK_STOP
      |-> ##2 compare_output_a != $past(compare_output_a))
    else $error("forced toggle missing");
  com_off_hold_a: assert property (
    compare_output_mode_a == COM_OFF |-> ##2 $stable(compare_output_a))
    else $error("output moved with mode off");
  osc_idle_a: assert property (
    !async_clock_select [*2] |-> !crystal_osc_out)
    else $error("oscillator output active");
endmodule : timer8_core_checker

bind timer8_core timer8_core_checker i_chk (.clk, .rst, .timer_power_reduction_bit,
  .async_clock_select, .tick_source_select, .waveform_mode_field, .compare_output_mode_a,
  .force_compare_strobe_a, .cpu_wr, .flag_clr, .timer_mask_register, .counter_value,
  .timer_flag_register, .compare_output_a, .irq_reg, .bottom_reg, .crystal_osc_out);

// [testbench/cpu_model.sv]
`timescale 1ns/1ps
module cpu_model
  import timer8_pkg::*;
(
  // Clock and reset
  input  wire logic [0:0] clk,
  input  wire logic       rst,
  // Interrupt side
  input  wire logic [2:0] irq_reg,
  input  wire logic       service_en,
  // Software write-one clears
  input  wire logic [2:0] sw_clear,
  output flag_clear_t     flag_clr
);
  // Servicing keeps clearing while a request is seen; the core lets a set win
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flag_clr <= '0;
    else
      flag_clr.clear <= sw_clear | (service_en ? irq_reg : 3'h0);
  end
endmodule : cpu_model

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
  import timer8_pkg::*;
  logic        clk, rst, pwr, async_sel, pre_tick, xtal, fa, fb, svc;
  logic [2:0]  sel, wgm, mask, sw_clr, flags, irq;
  logic [1:0]  com;
  cpu_write_t  wr;
  flag_clear_t fclr;
  logic [7:0]  cnt, ca, cb;
  logic        oa, ob, bot, xout;
  int          err_total, n_compared, cycles;
  logic [1:0]  com_tab [5] = '{COM_SET, COM_OFF, COM_TOGGLE, COM_CLEAR, COM_TOGGLE};
  logic        exp_tab [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  ////////////////////////////////////////////////////////////////////////////////
  timer8_core i_timer8_core (.clk(clk), .rst(rst), .timer_power_reduction_bit(pwr),
    .async_clock_select(async_sel), .tick_source_select(sel), .prescale_tick(pre_tick),
    .crystal_osc_in(xtal), .waveform_mode_field(wgm), .compare_output_mode_a(com),
    .compare_output_mode_b(com), .force_compare_strobe_a(fa), .force_compare_strobe_b(fb),
    .cpu_wr(wr), .flag_clr(fclr), .timer_mask_register(mask), .counter_value(cnt),
    .compare_value_a(ca), .compare_value_b(cb), .timer_flag_register(flags),
    .compare_output_a(oa), .compare_output_b(ob), .irq_reg(irq), .bottom_reg(bot),
    .crystal_osc_out(xout));
  cpu_model i_cpu_model (.clk(clk), .rst(rst), .irq_reg(irq), .service_en(svc),
    .sw_clear(sw_clr), .flag_clr(fclr));

  ////////////////////////////////////////////////////////////////////////////////
  // Inputs change 1 ns after the edge so the core never races the bench
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // One-cycle write strobe: k 0 counter, 1 compare A, 2 compare B
  // An idle cycle follows so back-to-back calls never touch wr twice at once
  task write(input int k, input logic [7:0] v);
    {wr.count_we, wr.cmp_a_we, wr.cmp_b_we} = 3'b100 >> k;
    wr.wdata = v;
    cyc(1);
    wr = '0;
    cyc(1);
  endtask : write
  // Exactly n ticks, stopped before and after
  task ticks(input int n);
    sel = TICK_DIV1;
    cyc(n);
    sel = TICK_STOP;
  endtask : ticks
  task clear_flags;
    sw_clr = 3'h7;
    cyc(1);
    sw_clr = 3'h0;
    cyc(3);
  endtask : clear_flags
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst       = 1'b1;
    pwr       = 1'b0;
    async_sel = 1'b0;
    pre_tick  = 1'b0;
    xtal      = 1'b0;
    fa        = 1'b0;
    fb        = 1'b0;
    svc       = 1'b0;
    sel       = TICK_STOP;
    wgm       = WGM_NORMAL;
    mask      = 3'h0;
    sw_clr    = 3'h0;
    com       = COM_OFF;
    wr        = '0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    cyc(1);
    `CHK("reset counter", 8'h00, cnt)
    `CHK("reset compares", 16'h0000, {ca, cb})
    `CHK("reset flags", 3'h0, flags)
    `CHK("reset outputs", 3'h0, {oa, ob, xout})
    write(0, 8'h05);
    cyc(6);
    `CHK("stopped write", 8'h05, cnt)
    pwr = 1'b1;
    ticks(5);
    pwr = 1'b0;
    cyc(2);
    `CHK("gated counter", 8'h05, cnt)
    write(0, 8'hfd);
    ticks(3);
    cyc(2);
    `CHK("wrap value", 8'h00, cnt)
    `CHK("bottom", 1'b1, bot)
    `CHK("overflow flag", 3'h1, flags)
    mask = 3'h1;
    cyc(2);
    `CHK("irq", 3'h1, irq)
    svc = 1'b1;
    cyc(5);
    svc = 1'b0;
    `CHK("serviced", 6'h00, {flags, irq})
    write(2, 8'h20);
    write(0, 8'h20);
    ticks(3);
    cyc(2);
    `CHK("blocked match", 3'h0, flags)
    write(0, 8'h1e);
    ticks(4);
    cyc(2);
    `CHK("match B flag", 3'h4, flags)
    sw_clr = 3'h4;
    cyc(1);
    sw_clr = 3'h0;
    cyc(3);
    `CHK("write-one clear", 3'h0, flags)
    wgm = WGM_CTC;
    write(1, 8'h03);
    write(0, 8'h00);
    ticks(6);
    cyc(2);
    `CHK("ctc count", 8'h02, cnt)
    `CHK("ctc flag", 3'h2, flags)
    `CHK("compare A direct", 8'h03, ca)
    clear_flags();
    // Active B still holds 0x20 until the top of the sequence
    wgm = WGM_FAST_MAX;
    write(2, 8'h50);
    cyc(2);
    `CHK("buffer readback", 8'h50, cb)
    write(0, 8'h1e);
    ticks(4);
    cyc(2);
    `CHK("old active B", 1'b1, flags[FLAG_CMB])
    clear_flags();
    write(0, 8'hfe);
    ticks(3);
    write(0, 8'h4e);
    ticks(4);
    cyc(2);
    `CHK("reloaded B", 3'h5, flags)
    clear_flags();
    // Forcing in normal mode sets up the output state before use
    wgm = WGM_NORMAL;
    write(0, 8'h10);
    for (int i = 0; i < 5; i++)
    begin
      com = com_tab[i];
      fa = 1'b1;
      fb = 1'b1;
      cyc(1);
      fa = 1'b0;
      fb = 1'b0;
      cyc(2);
      `CHK("forced outputs", {2{exp_tab[i]}}, {oa, ob})
    end
    `CHK("force side effects", 11'h010, {flags, cnt})
    wgm = WGM_FAST_MAX;
    fa = 1'b1;
    cyc(1);
    fa = 1'b0;
    wgm = WGM_NORMAL;
    cyc(2);
    `CHK("state kept", 1'b1, oa)
    sel = 3'h4;
    repeat (2)
    begin
      pre_tick = 1'b1;
      cyc(1);
      pre_tick = 1'b0;
      cyc(2);
    end
    sel = TICK_STOP;
    cyc(2);
    `CHK("prescaled ticks", 8'h12, cnt)
    // Oscillator drive echoes the synchronised crystal inverted
    async_sel = 1'b1;
    sel = TICK_DIV1;
    repeat (3)
    begin
      xtal = 1'b1;
      cyc(4);
      `CHK("osc echo low", 1'b0, xout)
      xtal = 1'b0;
      cyc(4);
      `CHK("osc echo high", 1'b1, xout)
    end
    sel = TICK_STOP;
    async_sel = 1'b0;
    cyc(2);
    `CHK("crystal ticks", 8'h15, cnt)
    // Dual slope with top at compare A: up to 3, down to 0, overflow there
    wgm = WGM_PC_OCA;
    write(0, 8'h01);
    ticks(6);
    cyc(2);
    `CHK("dual slope count", 8'h01, cnt)
    `CHK("dual slope flags", 3'h3, flags)
    give_verdict();
  end
endmodule : tb_top
